/* rxs_pkg.sv */
// rxs_pkg: constants and types of the mac-facing receive signalling block
// Operation
// - rxd bits 3..0 go to the mac on the receive clock in mii, gmii and rgmii.
// - rxd bits 7..4 carry data only in gmii and stay low otherwise.
// - in mii and gmii rx data valid is high while a nibble or byte is valid.
// - in rgmii the control line carries valid on the rise and valid xor error on the fall.
// - rx error goes high with the receive clock when a receive error is seen.
// - in rgmii the rx error, collision and carrier sense outputs stay low.
// - in half duplex collision is high while receive and transmit overlap.
// - in full duplex collision stays low.
// - in half duplex carrier sense is high on receive or transmit activity.
// - in 10/100 full duplex carrier sense follows received packets only.
// - the receive clock toggles on every link clock rise, at half the link clock rate, whatever the link speed.
package rxs_pkg;
  localparam int unsigned WORD_W     = 10;
  localparam int unsigned WORD_LAST  = 8;
  localparam int unsigned WORD_ERR   = 9;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CFG_W      = 6;
  localparam logic [7:0]  FC_BYTE    = 8'h0E;
  localparam logic [7:0]  FC_PAIR    = 8'hEE;
  localparam logic [3:0]  NIB_ZERO   = 4'h0;

  typedef enum logic [1:0] {
    RXS_MII   = 2'h0,
    RXS_GMII  = 2'h1,
    RXS_RGMII = 2'h2
  } rxs_mode_t;

  typedef enum logic [1:0] {
    RXS_S10   = 2'h0,
    RXS_S100  = 2'h1,
    RXS_S1000 = 2'h2
  } rxs_speed_t;

  typedef enum logic [2:0] {
    LK_IDLE = 3'h1,
    LK_LOAD = 3'h2,
    LK_HALF = 3'h4
  } rxs_lstate_t;
endpackage

/* rxs_stream_if.sv */
// rxs_stream_if: valid/ready word stream between the block's modules
`timescale 1ns/1ps
interface rxs_stream_if;
  logic [rxs_pkg::WORD_W-1:0] data;
  logic                       valid;
  logic                       ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

/* rxs_sync.sv */
// rxs_sync: two flip-flop level synchroniser
`timescale 1ns/1ps
module rxs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rxs_sync_st_t;

  rxs_sync_st_t st_r;
  rxs_sync_st_t st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_in) begin
    st_r <= st_nxt;
  end

  assign q_out = st_r.s2;
endmodule

/* rxs_afifo.sv */
// rxs_afifo: dual-clock word fifo with gray-coded pointers
`timescale 1ns/1ps
module rxs_afifo #(
  parameter int unsigned W     = 10,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic wclk_in,
  input  wire logic wrst_in,
  input  wire logic rclk_in,
  input  wire logic rrst_in,
  rxs_stream_if.snk wr,
  rxs_stream_if.src rd
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             bin;
    logic [AW:0]             gray;
    logic                    room;
  } rxs_fw_t;

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic        empty;
  } rxs_fr_t;

  rxs_fw_t     w_r;
  rxs_fw_t     w_nxt;
  rxs_fr_t     r_r;
  rxs_fr_t     r_nxt;
  logic [AW:0] rgray_w;
  logic [AW:0] wgray_r;

  rxs_sync #(.W(AW+1)) u_rsync (
    .clk_in (wclk_in),
    .d_in   (r_r.gray),
    .q_out  (rgray_w)
  );

  rxs_sync #(.W(AW+1)) u_wsync (
    .clk_in (rclk_in),
    .d_in   (w_r.gray),
    .q_out  (wgray_r)
  );

  // full and empty are registered, so ready and valid come from flops
  always_comb begin
    w_nxt = w_r;
    if (wr.valid && w_r.room) begin
      w_nxt.mem[w_r.bin[AW-1:0]] = wr.data;
      w_nxt.bin                  = w_r.bin + (AW+1)'(1);
    end
    w_nxt.gray = w_nxt.bin ^ (w_nxt.bin >> 1);
    // room kept as a flop so ready leaves without an inverter
    w_nxt.room = w_nxt.gray != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]};
    if (wrst_in) begin
      w_nxt      = '0;
      w_nxt.room = 1'h1;
    end
  end

  always_comb begin
    r_nxt = r_r;
    if (rd.ready && !r_r.empty) begin
      r_nxt.bin = r_r.bin + (AW+1)'(1);
    end
    r_nxt.gray  = r_nxt.bin ^ (r_nxt.bin >> 1);
    r_nxt.empty = r_nxt.gray == wgray_r;
    if (rrst_in) begin
      r_nxt       = '0;
      r_nxt.empty = 1'h1;
    end
  end

  always_ff @(posedge wclk_in) begin
    w_r <= w_nxt;
  end

  always_ff @(posedge rclk_in) begin
    r_r <= r_nxt;
  end

  assign wr.ready = w_r.room;
  assign rd.valid = ~r_r.empty;
  // word under the read pointer is stable once its pointer has crossed
  assign rd.data  = w_r.mem[r_r.bin[AW-1:0]];
endmodule

/* rxs_top.sv */
// rxs_top: receive data, control and status outputs toward the mac
`timescale 1ns/1ps
module rxs_top (
  input  wire logic                clock_in,
  input  wire logic                rst_in,
  input  wire logic                link_clk_in,
  input  wire rxs_pkg::rxs_mode_t  mode_in,
  input  wire rxs_pkg::rxs_speed_t speed_in,
  input  wire logic                full_duplex_in,
  input  wire logic                link_up_in,
  input  wire logic [7:0]          rx_byte_in,
  input  wire logic                rx_valid_in,
  input  wire logic                rx_last_in,
  input  wire logic                rx_err_in,
  input  wire logic                false_carrier_in,
  input  wire logic                rx_carrier_in,
  input  wire logic                tx_en_ctrl_in,
  output logic                     rx_ready_out,
  output logic                     rx_clk_out,
  output logic [7:0]               rxd_out,
  output logic                     rx_dv_ctrl_out,
  output logic                     rx_er_out,
  output logic                     col_out,
  output logic                     crs_out
);
  typedef struct packed {
    logic fc_tgl;
    logic crs;
    logic col;
  } rxs_core_t;

  typedef struct packed {
    rxs_pkg::rxs_lstate_t st;
    logic                 clk;
    logic [7:0]           hold;
    logic                 dv;
    logic                 er;
    logic                 last;
    logic                 fc_seen;
    logic                 fc_pend;
    logic [7:0]           rxd;
    logic                 ctrl;
    logic                 rxer;
  } rxs_link_t;

  rxs_core_t                   c_r;
  rxs_core_t                   c_nxt;
  rxs_link_t                   l_r;
  rxs_link_t                   l_nxt;
  logic                        tx_act;
  logic                        lrst;
  logic                        fc_s;
  logic [rxs_pkg::CFG_W-1:0]   cfg_s;
  rxs_pkg::rxs_mode_t          cfg_mode;
  rxs_pkg::rxs_speed_t         cfg_speed;
  logic                        cfg_dup;
  logic                        cfg_link;
  logic                        rgmii;
  logic                        gmii;
  logic                        go;
  logic                        idle;
  logic                        pop;
  logic [7:0]                  b;
  logic                        b_dv;
  logic                        b_er;
  logic                        b_last;

  rxs_stream_if wr_s ();
  rxs_stream_if rd_s ();

  // tx enable arrives on the mac's transmit clock
  rxs_sync #(.W(1)) u_txsync (
    .clk_in (clock_in),
    .d_in   (tx_en_ctrl_in),
    .q_out  (tx_act)
  );

  rxs_sync #(.W(1)) u_rstsync (
    .clk_in (link_clk_in),
    .d_in   (rst_in),
    .q_out  (lrst)
  );

  rxs_sync #(.W(1)) u_fcsync (
    .clk_in (link_clk_in),
    .d_in   (c_r.fc_tgl),
    .q_out  (fc_s)
  );

  // configuration is quasi-static, so per-bit sync is enough
  rxs_sync #(.W(rxs_pkg::CFG_W)) u_cfgsync (
    .clk_in (link_clk_in),
    .d_in   ({mode_in, speed_in, full_duplex_in, link_up_in}),
    .q_out  (cfg_s)
  );

  assign cfg_mode  = rxs_pkg::rxs_mode_t'(cfg_s[5:4]);
  assign cfg_speed = rxs_pkg::rxs_speed_t'(cfg_s[3:2]);
  assign cfg_dup   = cfg_s[1];
  assign cfg_link  = cfg_s[0];

  assign wr_s.data  = {rx_err_in, rx_last_in, rx_byte_in};
  assign wr_s.valid = rx_valid_in;
  assign rd_s.ready = pop;

  rxs_afifo #(
    .W     (rxs_pkg::WORD_W),
    .DEPTH (rxs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .wclk_in (clock_in),
    .wrst_in (rst_in),
    .rclk_in (link_clk_in),
    .rrst_in (lrst),
    .wr      (wr_s),
    .rd      (rd_s)
  );

  // core clock: status outputs and false carrier event
  always_comb begin
    c_nxt     = c_r;
    c_nxt.crs = 1'h0;
    c_nxt.col = 1'h0;
    if (false_carrier_in) begin
      c_nxt.fc_tgl = ~c_r.fc_tgl;
    end
    // tx_act depends on the mac framing tx enable
    if (mode_in != rxs_pkg::RXS_RGMII) begin
      if (!full_duplex_in) begin
        c_nxt.crs = rx_carrier_in | tx_act;
        c_nxt.col = rx_carrier_in & tx_act;
      end else if (speed_in != rxs_pkg::RXS_S1000) begin
        // undefined at 1000 full duplex, held low there
        c_nxt.crs = rx_carrier_in;
      end
    end
    // full duplex leaves col at its default low
    if (rst_in) begin
      c_nxt = '0;
    end
  end

  always_ff @(posedge clock_in) begin
    c_r <= c_nxt;
  end

  // link clock: one half period of the receive clock per edge
  always_comb begin
    l_nxt  = l_r;
    pop    = 1'h0;
    go     = 1'h0;
    idle   = 1'h0;
    b      = l_r.hold;
    b_dv   = 1'h0;
    b_er   = 1'h0;
    b_last = 1'h1;
    rgmii  = cfg_mode == rxs_pkg::RXS_RGMII;
    gmii   = cfg_mode == rxs_pkg::RXS_GMII;
    l_nxt.clk = ~l_r.clk;
    if (l_r.st == rxs_pkg::LK_HALF) begin
      // second nibble: next fall in mii, same period's fall in rgmii
      if (l_r.clk) begin
        l_nxt.rxd  = {rxs_pkg::NIB_ZERO, l_r.hold[7:4]};
        l_nxt.ctrl = rgmii ? (l_r.dv ^ l_r.er) : l_r.dv;
        l_nxt.rxer = rgmii ? 1'h0 : l_r.er;
        l_nxt.st   = l_r.last ? rxs_pkg::LK_IDLE : rxs_pkg::LK_LOAD;
      end
    end else if (rgmii ? !l_r.clk : l_r.clk) begin
      go = 1'h1;
      if (rd_s.valid) begin
        pop    = 1'h1;
        b      = rd_s.data[7:0];
        b_dv   = 1'h1;
        b_er   = rd_s.data[rxs_pkg::WORD_ERR];
        b_last = rd_s.data[rxs_pkg::WORD_LAST];
      end else if (l_r.st == rxs_pkg::LK_LOAD) begin
        // fifo ran dry inside a frame: keep valid, flag it as errored
        b_dv   = 1'h1;
        b_er   = 1'h1;
        b_last = 1'h0;
      end else if (l_r.fc_pend) begin
        b             = gmii ? rxs_pkg::FC_BYTE : rxs_pkg::FC_PAIR;
        b_er          = 1'h1;
        l_nxt.fc_pend = 1'h0;
      end else begin
        go   = 1'h0;
        idle = 1'h1;
      end
    end
    if (go) begin
      l_nxt.hold = b;
      l_nxt.dv   = b_dv;
      l_nxt.er   = b_er;
      l_nxt.last = b_last;
      l_nxt.rxd  = gmii ? b : {rxs_pkg::NIB_ZERO, b[3:0]};
      l_nxt.ctrl = b_dv;
      l_nxt.rxer = rgmii ? 1'h0 : b_er;
      if (gmii) begin
        l_nxt.st = b_last ? rxs_pkg::LK_IDLE : rxs_pkg::LK_LOAD;
      end else begin
        l_nxt.st = rxs_pkg::LK_HALF;
      end
    end else if (idle) begin
      // rgmii idle carries in-band link status on the data lines
      if (rgmii) begin
        l_nxt.rxd = {rxs_pkg::NIB_ZERO, cfg_dup, cfg_speed, cfg_link};
      end else begin
        l_nxt.rxd = '0;
      end
      l_nxt.ctrl = 1'h0;
      l_nxt.rxer = 1'h0;
    end
    // a new event after the clear above wins
    if (fc_s != l_r.fc_seen) begin
      l_nxt.fc_seen = fc_s;
      l_nxt.fc_pend = 1'h1;
    end
    if (lrst) begin
      l_nxt    = '0;
      l_nxt.st = rxs_pkg::LK_IDLE;
    end
  end

  always_ff @(posedge link_clk_in) begin
    l_r <= l_nxt;
  end

  assign rx_ready_out   = wr_s.ready;
  assign rx_clk_out     = l_r.clk;
  assign rxd_out        = l_r.rxd;
  assign rx_dv_ctrl_out = l_r.ctrl;
  assign rx_er_out      = l_r.rxer;
  assign col_out        = c_r.col;
  assign crs_out        = c_r.crs;
endmodule

/* rxs_props.sv */
// rxs_props: assertion checker on the top module ports
`timescale 1ns/1ps
module rxs_props (
  input wire logic                clock_in,
  input wire logic                rst_in,
  input wire logic                link_clk_in,
  input wire rxs_pkg::rxs_mode_t  mode_in,
  input wire rxs_pkg::rxs_speed_t speed_in,
  input wire logic                full_duplex_in,
  input wire logic                link_up_in,
  input wire logic [7:0]          rx_byte_in,
  input wire logic                rx_valid_in,
  input wire logic                rx_last_in,
  input wire logic                rx_err_in,
  input wire logic                false_carrier_in,
  input wire logic                rx_carrier_in,
  input wire logic                tx_en_ctrl_in,
  input wire logic                rx_ready_out,
  input wire logic                rx_clk_out,
  input wire logic [7:0]          rxd_out,
  input wire logic                rx_dv_ctrl_out,
  input wire logic                rx_er_out,
  input wire logic                col_out,
  input wire logic                crs_out
);
  rxs_pkg::rxs_mode_t mq_r;
  logic [2:0]         lc_r = 3'h0;
  logic [4:0]         cq_r;
  logic               ok;
  logic               st;
  logic               hd;
  // link checks wait until reset and a mode change have settled there
  always_ff @(posedge link_clk_in) begin
    mq_r <= mode_in;
    if (rst_in || mode_in != mq_r) lc_r <= 3'h0;
    else if (lc_r != 3'h4) lc_r <= lc_r + 3'h1;
  end
  always_ff @(posedge clock_in) cq_r <= {mode_in, speed_in, full_duplex_in};
  assign ok = lc_r == 3'h4;
  assign st = cq_r == {mode_in, speed_in, full_duplex_in};
  assign hd = !full_duplex_in && mode_in != rxs_pkg::RXS_RGMII;

  chk_col_idle: assert property (@(posedge clock_in) disable iff (rst_in)
    !rx_carrier_in |=> !col_out) else $error("collision without carrier");
  chk_col_both: assert property (@(posedge clock_in) disable iff (rst_in)
    (hd && rx_carrier_in && tx_en_ctrl_in) [*4] |=> col_out) else $error("collision missed");
  chk_col_full: assert property (@(posedge clock_in) disable iff (rst_in)
    full_duplex_in && st |-> !col_out) else $error("collision in full duplex");
  chk_crs_half: assert property (@(posedge clock_in) disable iff (rst_in)
    (hd && rx_carrier_in) [*2] |=> crs_out) else $error("carrier sense missed");
  chk_crs_fd: assert property (@(posedge clock_in) disable iff (rst_in)
    full_duplex_in && st && mode_in != rxs_pkg::RXS_RGMII && speed_in != rxs_pkg::RXS_S1000
    |-> crs_out == $past(rx_carrier_in)) else $error("carrier sense not on receive");
  chk_crs_gig: assert property (@(posedge clock_in) disable iff (rst_in)
    full_duplex_in && st && speed_in == rxs_pkg::RXS_S1000 |-> !crs_out)
    else $error("carrier sense at gigabit full duplex");
  chk_status_quiet: assert property (@(posedge clock_in) disable iff (rst_in)
    mode_in == rxs_pkg::RXS_RGMII && st |-> !col_out && !crs_out) else $error("status in rgmii");
  chk_er_quiet: assert property (@(posedge link_clk_in) disable iff (!ok)
    mode_in == rxs_pkg::RXS_RGMII |-> !rx_er_out) else $error("rx error in rgmii");
  chk_upper_zero: assert property (@(posedge link_clk_in) disable iff (!ok)
    mode_in != rxs_pkg::RXS_GMII |-> rxd_out[7:4] == 4'h0) else $error("upper nibble driven");
  chk_rxclk_half: assert property (@(posedge link_clk_in) disable iff (!ok)
    rx_clk_out != $past(rx_clk_out)) else $error("receive clock stalled");
endmodule

bind rxs_top rxs_props chk (.*);

/* rxs_mac_model.sv */
// rxs_mac_model: mac side receiver and transmit enable source
`timescale 1ns/1ps
module rxs_mac_model (
  input  wire logic               link_clk_in,
  input  wire rxs_pkg::rxs_mode_t mode_in,
  input  wire logic               rx_clk_in,
  input  wire logic [7:0]         rxd_in,
  input  wire logic               ctrl_in,
  input  wire logic               er_in,
  output logic                    tx_en_out
);
  logic [8:0] got[$];
  logic [3:0] lo = 4'h0;
  logic       dv = 1'b0;
  logic       hi = 1'b0;
  logic       gtx = 1'b0;
  initial tx_en_out = 1'b0;
  // own transmit clock, unrelated to both clocks of the block
  always #4 gtx = !gtx;
  // same level on both edges: enable with error low
  task automatic send(input int n);
    repeat (n) @(posedge gtx) tx_en_out <= 1'b1;
    @(posedge gtx) tx_en_out <= 1'b0;
  endtask
  // sample mid-beat: beats move on the link clock rise
  always @(negedge link_clk_in) begin
    if (rx_clk_in) begin
      lo = rxd_in[3:0];
      dv = ctrl_in;
    end else if (mode_in == rxs_pkg::RXS_RGMII) begin
      if (dv) got.push_back({dv ^ ctrl_in, rxd_in[3:0], lo});
    end else if (mode_in == rxs_pkg::RXS_GMII) begin
      if (ctrl_in) got.push_back({er_in, rxd_in});
    end else if (!ctrl_in) hi = 1'b0;
    else begin
      if (hi) got.push_back({er_in, rxd_in[3:0], lo});
      else lo = rxd_in[3:0];
      hi = !hi;
    end
  end
endmodule

/* tb.sv */
// tb: directed bench for the receive signalling block
`timescale 1ns/1ps
module tb;
  logic                clock_in = 1'b0;
  logic                link_clk = 1'b0;
  logic                rst_in = 1'b1;
  rxs_pkg::rxs_mode_t  mode = rxs_pkg::RXS_GMII;
  rxs_pkg::rxs_speed_t speed = rxs_pkg::RXS_S1000;
  logic                fd = 1'b1;
  logic                car = 1'b0;
  logic [7:0]          din = 8'h00;
  logic                valid = 1'b0;
  logic                last = 1'b0;
  logic                err = 1'b0;
  logic                fc = 1'b0;
  logic                ready, rx_clk, dv, er, col, crs, tx_en;
  logic [7:0]          rxd;
  int                  failures = 0;
  int                  comparisons = 0;

  always #10 clock_in = !clock_in;
  always #62.5 link_clk = !link_clk;

  rxs_top dut (.clock_in(clock_in), .rst_in(rst_in), .link_clk_in(link_clk),
    .mode_in(mode), .speed_in(speed), .full_duplex_in(fd), .link_up_in(1'b1),
    .rx_byte_in(din), .rx_valid_in(valid), .rx_last_in(last), .rx_err_in(err),
    .false_carrier_in(fc), .rx_carrier_in(car), .tx_en_ctrl_in(tx_en),
    .rx_ready_out(ready), .rx_clk_out(rx_clk), .rxd_out(rxd), .rx_dv_ctrl_out(dv),
    .rx_er_out(er), .col_out(col), .crs_out(crs));
  rxs_mac_model mac (.link_clk_in(link_clk), .mode_in(mode), .rx_clk_in(rx_clk),
    .rxd_in(rxd), .ctrl_in(dv), .er_in(er), .tx_en_out(tx_en));

  task automatic cmp(input logic [9:0] g, input logic [9:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic stop_test;
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // 24 words overrun the 16-deep fifo, so the writer sees back-pressure
  task automatic t_frame(input rxs_pkg::rxs_mode_t m);
    logic [8:0] e[$];
    int         k;
    logic       full;
    @(negedge clock_in);
    mode = m;
    full = 1'b0;
    repeat (40) @(negedge clock_in);
    mac.got.delete();
    for (int i = 0; i < 24; i++) begin
      e.push_back({1'(i == 9), 8'(i * 8'h1D) ^ 8'hA5});
      din = e[i][7:0];
      err = e[i][8];
      last = (i == 23);
      valid = 1'b1;
      while (!ready) begin
        full = 1'b1;
        @(negedge clock_in);
      end
      @(negedge clock_in);
    end
    valid = 1'b0;
    last = 1'b0;
    err = 1'b0;
    k = 0;
    while (mac.got.size() < 24 && k < 2000) begin
      @(negedge clock_in);
      k++;
    end
    repeat (40) @(negedge clock_in);
    cmp(10'(mac.got.size()), 10'h018);
    cmp({9'h000, full}, 10'h001);
    foreach (e[i]) cmp(10'(mac.got[i]), 10'(e[i]));
  endtask

  // rows: mode, speed, duplex, carrier, then expected collision and carrier sense
  task automatic t_status;
    logic [7:0] t[6] = '{8'h57, 8'h51, 8'h5D, 8'h58, 8'h6C, 8'hA4};
    fork
      mac.send(400);
    join_none
    foreach (t[i]) begin
      @(negedge clock_in);
      mode = rxs_pkg::rxs_mode_t'(t[i][7:6]);
      speed = rxs_pkg::rxs_speed_t'(t[i][5:4]);
      fd = t[i][3];
      car = t[i][2];
      repeat (8) @(negedge clock_in);
      cmp({8'h00, col, crs}, {8'h00, t[i][1:0]});
    end
    car = 1'b0;
  endtask

  // rgmii idle shows duplex, speed and link state in band
  task automatic t_idle;
    repeat (40) @(negedge clock_in);
    cmp({dv, er, rxd}, 10'h005);
  endtask

  // gmii false carrier: one beat of 0x0E with error and no valid
  task automatic t_false;
    int k;
    @(negedge clock_in);
    mode = rxs_pkg::RXS_GMII;
    repeat (40) @(negedge clock_in);
    fc = 1'b1;
    @(negedge clock_in);
    fc = 1'b0;
    k = 0;
    while (!er && k < 100) begin
      @(negedge clock_in);
      k++;
    end
    cmp({dv, er, rxd}, 10'h10E);
  endtask

  initial begin
    // link side takes its reset through two flops, so reset is held longer
    repeat (30) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (10) @(negedge clock_in);
    t_frame(rxs_pkg::RXS_GMII);
    t_frame(rxs_pkg::RXS_MII);
    t_frame(rxs_pkg::RXS_RGMII);
    t_status;
    t_idle;
    t_false;
    stop_test;
  end

  initial begin
    #300us;
    failures++;
    stop_test;
  end
endmodule
